// *** verilog/tmr8c_timer.sv ***
// Purpose: 8-bit timer/counter with two compare channels on APB.
// Assumes: pclk is the io_clock; osc_pin_in is asynchronous.
// Notes:   Phase-correct modes count like fast PWM here.
//
// Function
// - 8-bit counter, two compares, equality comparators
// - clock select zero stops the counter
// - async select switches timer clock to oscillator
// - bottom is 0x00, maximum is 0xFF
// - top is 0xFF or compare A
// - counter clears or counts per waveform mode
// - counter readable and writable without timer clock
// - software counter write beats clear and count
// - mode field split over both control registers
// - overflow flag set per mode, can interrupt
// - match sets compare flag on next tick
// - compare flag requests, clears on service or one
// - flags visible, each gated by mask bit
// - compares buffered only in PWM modes
// - buffered compare loads only at top
// - software reaches buffer or active compare
// - force strobe acts like match outside PWM, no flag
// - counter write blocks matches next tick
// - output action changes apply at once
// - output state kept across mode changes
// - normal mode wraps and sets overflow at zero
// - clear-on-compare mode clears at compare A
// - fast PWM top 0xFF or compare A
// - action zero leaves output unchanged
`default_nettype none

module tmr8c_timer
	import tmr8c_pkg::*;
#(
	parameter int PRESC_W = 10
)
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Interrupt requests and service acknowledge
	input wire logic [2:0] irq_ack,
	output logic [2:0] irq_req,
	// Pins
	input wire logic osc_pin_in,
	output logic compare_output_a,
	output logic compare_output_b
);

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic [PRESC_W-1:0] presc_mask(input logic [2:0] cs);
		logic [PRESC_W-1:0] m;
		case (cs)
			3'h2: m = PRESC_W'(7);
			3'h3: m = PRESC_W'(31);
			3'h4: m = PRESC_W'(63);
			3'h5: m = PRESC_W'(127);
			3'h6: m = PRESC_W'(255);
			3'h7: m = PRESC_W'(1023);
			default: m = '0;
		endcase
		return m;
	endfunction

	// Next compare output state for a match and a restart at bottom
	function automatic logic wave(input logic cur, input logic [1:0] act, input logic pwm_m,
		input logic hit, input logic bot);
		logic r;
		r = cur;
		if (hit && act != ACT_NONE)
		begin
			if (act == ACT_TOGGLE)
				r = pwm_m ? cur : ~cur;
			else
				r = (act == ACT_SET);
		end
		if (pwm_m && bot && act[1])
			r = (act == ACT_CLEAR);
		return r;
	endfunction

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	logic [7:0] cnt_r, cnt_nxt;
	logic [7:0] ocr_a_r, ocr_a_nxt, ocr_b_r, ocr_b_nxt;
	logic [7:0] buf_a_r, buf_a_nxt, buf_b_r, buf_b_nxt;
	tmr8c_ctla_t ctla_r;
	tmr8c_ctlb_t ctlb_r;
	tmr8c_flags_t flags_r, flags_nxt;
	logic [2:0] mask_r;
	logic async_sel_r;
	logic block_r, block_nxt;
	logic [PRESC_W-1:0] presc_r;
	logic osc_s1_r, osc_s2_r, osc_s3_r;
	logic [31:0] rdata;
	logic out_a_nxt, out_b_nxt;

	// ---------------------------------------------------------------
	// APB decode
	// ---------------------------------------------------------------
	wire logic setup = psel & ~penable;
	wire logic hit_ctla = (paddr == ADDR_CTRL_A);
	wire logic hit_ctlb = (paddr == ADDR_CTRL_B);
	wire logic hit_cnt = (paddr == ADDR_COUNT);
	wire logic hit_cmpa = (paddr == ADDR_CMP_A);
	wire logic hit_cmpb = (paddr == ADDR_CMP_B);
	wire logic hit_mask = (paddr == ADDR_MASK);
	wire logic hit_flags = (paddr == ADDR_FLAGS);
	wire logic hit_async = (paddr == ADDR_ASYNC);
	wire logic mapped = hit_ctla | hit_ctlb | hit_cnt | hit_cmpa | hit_cmpb | hit_mask | hit_flags | hit_async;
	wire logic wr = psel & penable & pready & pwrite & mapped;
	wire logic wr_cnt = wr & hit_cnt;

	// ---------------------------------------------------------------
	// Mode decode
	// ---------------------------------------------------------------
	// mode bits from both control registers
	wire logic [2:0] mode = {ctlb_r.waveform_mode_bit2, ctla_r.waveform_mode_bit1, ctla_r.waveform_mode_bit0};
	// odd modes are the PWM modes
	wire logic pwm = mode[0];
	// top from compare A or fixed maximum
	wire logic [7:0] top_val = (mode == MODE_CTC || mode == MODE_FAST_OCA) ? ocr_a_r : CNT_MAX;
	wire logic at_max = (cnt_r == CNT_MAX);
	wire logic at_top = (cnt_r == top_val);

	// ---------------------------------------------------------------
	// Timer clock
	// ---------------------------------------------------------------
	// oscillator edges replace io_clock when selected
	wire logic base_en = async_sel_r ? (osc_s2_r & ~osc_s3_r) : 1'b1;
	wire logic [PRESC_W-1:0] pmask = presc_mask(ctlb_r.clock_select_field);
	// no tick with clock select zero
	wire logic tick = base_en && (ctlb_r.clock_select_field != CS_STOP) && ((presc_r & pmask) == pmask);

	// ---------------------------------------------------------------
	// Compare and counter
	// ---------------------------------------------------------------
	// equality comparators
	wire logic match_a = (cnt_r == ocr_a_r);
	wire logic match_b = (cnt_r == ocr_b_r);
	// matches blocked for one tick after a counter write
	wire logic evt_a = tick & match_a & ~block_r;
	wire logic evt_b = tick & match_b & ~block_r;
	wire logic restart = tick & pwm & at_top;
	wire logic ctc_clr = evt_a & (mode == MODE_CTC);
	wire logic force_a = wr & hit_ctlb & pwdata[FORCE_A_BIT] & ~pwm;
	wire logic force_b = wr & hit_ctlb & pwdata[FORCE_B_BIT] & ~pwm;
	// overflow at wrap outside PWM, at top in PWM
	wire logic ovf_set = pwm ? restart : (tick & at_max);

	assign cnt_nxt = wr_cnt ? pwdata[7:0] :
		(restart | ctc_clr) ? CNT_BOTTOM :
		tick ? 8'(cnt_r + 8'h01) : cnt_r;
	assign block_nxt = wr_cnt ? 1'b1 : (tick ? 1'b0 : block_r);

	// writes reach buffer in PWM, active register otherwise
	assign buf_a_nxt = (wr & hit_cmpa) ? pwdata[7:0] : buf_a_r;
	assign buf_b_nxt = (wr & hit_cmpb) ? pwdata[7:0] : buf_b_r;
	assign ocr_a_nxt = (wr & hit_cmpa & ~pwm) ? pwdata[7:0] : (restart ? buf_a_r : ocr_a_r);
	assign ocr_b_nxt = (wr & hit_cmpb & ~pwm) ? pwdata[7:0] : (restart ? buf_b_r : ocr_b_r);

	// actions used straight from the control register
	assign out_a_nxt = wave(compare_output_a, ctla_r.action_a, pwm, evt_a | force_a, restart);
	assign out_b_nxt = wave(compare_output_b, ctla_r.action_b, pwm, evt_b | force_b, restart);

	// set wins over software or service clear
	assign flags_nxt = (flags_r & ~((wr & hit_flags) ? pwdata[2:0] : 3'h0) & ~irq_ack) |
		{evt_b, evt_a, ovf_set};

	// ---------------------------------------------------------------
	// Read mux
	// ---------------------------------------------------------------
	// force bits read as zero
	always_comb
	begin
		rdata = 32'h0000_0000;
		case (1'b1)
			hit_ctla: rdata[7:0] = ctla_r;
			hit_ctlb: rdata[4:0] = ctlb_r[4:0];
			hit_cnt: rdata[7:0] = cnt_r;
			hit_cmpa: rdata[7:0] = pwm ? buf_a_r : ocr_a_r;
			hit_cmpb: rdata[7:0] = pwm ? buf_b_r : ocr_b_r;
			hit_mask: rdata[2:0] = mask_r;
			hit_flags: rdata[2:0] = flags_r;
			hit_async: rdata[ASYNC_SEL_BIT] = async_sel_r;
			default: rdata = 32'h0000_0000;
		endcase
	end

	// ---------------------------------------------------------------
	// APB response
	// ---------------------------------------------------------------
	// Zero-wait access: answer is prepared during the setup cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else
		begin
			pready <= setup;
			pslverr <= setup & ~mapped;
			prdata <= (setup & ~pwrite) ? rdata : 32'h0000_0000;
		end
	end

	// ---------------------------------------------------------------
	// Configuration registers
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctla_r <= RST_BYTE;
			ctlb_r <= RST_BYTE;
			mask_r <= RST_MASK;
			async_sel_r <= 1'b0;
		end
		else
		begin
			if (wr & hit_ctla)
				ctla_r <= {pwdata[7:4], 2'b00, pwdata[1:0]};
			if (wr & hit_ctlb)
				ctlb_r <= {3'b000, pwdata[4:0]};
			if (wr & hit_mask)
				mask_r <= pwdata[2:0];
			if (wr & hit_async)
				async_sel_r <= pwdata[ASYNC_SEL_BIT];
		end
	end

	// ---------------------------------------------------------------
	// Oscillator synchroniser and prescaler
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			osc_s1_r <= 1'b0;
			osc_s2_r <= 1'b0;
			osc_s3_r <= 1'b0;
			presc_r <= '0;
		end
		else
		begin
			osc_s1_r <= osc_pin_in;
			osc_s2_r <= osc_s1_r;
			osc_s3_r <= osc_s2_r;
			if (base_en)
				presc_r <= PRESC_W'(presc_r + 1'b1);
		end
	end

	// ---------------------------------------------------------------
	// Counter, compares, flags and outputs
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_r <= RST_BYTE;
			ocr_a_r <= RST_BYTE;
			ocr_b_r <= RST_BYTE;
			buf_a_r <= RST_BYTE;
			buf_b_r <= RST_BYTE;
			block_r <= 1'b0;
			flags_r <= '0;
			irq_req <= 3'h0;
			compare_output_a <= 1'b0;
			compare_output_b <= 1'b0;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			ocr_a_r <= ocr_a_nxt;
			ocr_b_r <= ocr_b_nxt;
			buf_a_r <= buf_a_nxt;
			buf_b_r <= buf_b_nxt;
			block_r <= block_nxt;
			flags_r <= flags_nxt;
			irq_req <= flags_nxt & mask_r;
			// state never reset by a mode change
			compare_output_a <= out_a_nxt;
			compare_output_b <= out_b_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	property p_stop_hold;
		(ctlb_r.clock_select_field == CS_STOP) && !wr_cnt |=> $stable(cnt_r);
	endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("counter moved while stopped");

	property p_wr_prio;
		wr_cnt |=> cnt_r == $past(pwdata[7:0]);
	endproperty
	a_wr_prio: assert property (p_wr_prio) else $error("counter write lost");

	property p_block;
		tick && block_r && !flags_r.compare_flag_a && !flags_r.compare_flag_b
			|=> !flags_r.compare_flag_a && !flags_r.compare_flag_b;
	endproperty
	a_block: assert property (p_block) else $error("match not blocked after write");

	property p_cmpa_flag;
		tick && match_a && !block_r |=> flags_r.compare_flag_a;
	endproperty
	a_cmpa_flag: assert property (p_cmpa_flag) else $error("compare flag A not set");

	property p_normal_wrap;
		(mode == MODE_NORMAL) && tick && at_max && !wr_cnt |=> (cnt_r == CNT_BOTTOM) && flags_r.overflow_flag;
	endproperty
	a_normal_wrap: assert property (p_normal_wrap) else $error("normal wrap wrong");

	property p_ctc_clear;
		(mode == MODE_CTC) && tick && match_a && !block_r && !wr_cnt |=> cnt_r == CNT_BOTTOM;
	endproperty
	a_ctc_clear: assert property (p_ctc_clear) else $error("no clear on compare A");

	property p_buf_hold;
		pwm && !restart && $stable(mode) |=> ocr_a_r == $past(ocr_a_r);
	endproperty
	a_buf_hold: assert property (p_buf_hold) else $error("buffered compare changed off top");

	property p_force;
		force_a && (ctla_r.action_a == ACT_TOGGLE) |=> (compare_output_a != $past(compare_output_a))
			&& (flags_r.compare_flag_a == $past(flags_nxt.compare_flag_a));
	endproperty
	a_force: assert property (p_force) else $error("force strobe misbehaved");

	property p_act_none;
		(ctla_r.action_a == ACT_NONE) && $stable(ctla_r) |=> $stable(compare_output_a);
	endproperty
	a_act_none: assert property (p_act_none) else $error("output moved with action zero");

	property p_irq;
		flags_r.compare_flag_a && mask_r[1] ##1 flags_r.compare_flag_a && mask_r[1] |-> irq_req[1];
	endproperty
	a_irq: assert property (p_irq) else $error("masked request mismatch");

endmodule // tmr8c_timer

`default_nettype wire

// *** verilog/tmr8c_pkg.sv ***
// Purpose: Shared constants and field layouts of the 8-bit timer.
// Assumes: APB byte addresses, one register per 32-bit word.
// Notes:   Data sits in the low byte; upper bits read as zero.
`default_nettype none

package tmr8c_pkg;

	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL_A = 8'h00;
	localparam logic [7:0] ADDR_CTRL_B = 8'h04;
	localparam logic [7:0] ADDR_COUNT = 8'h08;
	localparam logic [7:0] ADDR_CMP_A = 8'h0c;
	localparam logic [7:0] ADDR_CMP_B = 8'h10;
	localparam logic [7:0] ADDR_MASK = 8'h14;
	localparam logic [7:0] ADDR_FLAGS = 8'h18;
	localparam logic [7:0] ADDR_ASYNC = 8'h1c;

	// ---------------------------------------------------------------
	// Field positions and reset values
	// ---------------------------------------------------------------
	localparam int FORCE_A_BIT = 7;
	localparam int FORCE_B_BIT = 6;
	localparam int ASYNC_SEL_BIT = 0;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [2:0] RST_MASK = 3'h0;

	// ---------------------------------------------------------------
	// Counter values, modes and output actions
	// ---------------------------------------------------------------
	localparam logic [7:0] CNT_BOTTOM = 8'h00;
	localparam logic [7:0] CNT_MAX = 8'hff;
	localparam logic [2:0] MODE_NORMAL = 3'h0;
	localparam logic [2:0] MODE_CTC = 3'h2;
	localparam logic [2:0] MODE_FAST = 3'h3;
	localparam logic [2:0] MODE_FAST_OCA = 3'h7;
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [1:0] ACT_NONE = 2'h0;
	localparam logic [1:0] ACT_TOGGLE = 2'h1;
	localparam logic [1:0] ACT_CLEAR = 2'h2;
	localparam logic [1:0] ACT_SET = 2'h3;

	// ---------------------------------------------------------------
	// Register layouts
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [1:0] action_a;
		logic [1:0] action_b;
		logic [1:0] rsvd;
		logic waveform_mode_bit1;
		logic waveform_mode_bit0;
	} tmr8c_ctla_t;

	typedef struct packed {
		logic force_a;
		logic force_b;
		logic [1:0] rsvd;
		logic waveform_mode_bit2;
		logic [2:0] clock_select_field;
	} tmr8c_ctlb_t;

	typedef struct packed {
		logic compare_flag_b;
		logic compare_flag_a;
		logic overflow_flag;
	} tmr8c_flags_t;

endpackage

`default_nettype wire

// *** verif/tmr8c_timer_test.sv ***
// Purpose: Self-checking bench for the 8-bit timer with compare channels.
// Assumes: APB answers within a few cycles; timer clock from pclk unless async select.
// Notes:   Oscillator pin is driven by the bench; each rising edge is one tick.
`default_nettype none

module tmr8c_timer_test;
	import tmr8c_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	// ---------------------------------------------------------------
	// Signals and instance
	// ---------------------------------------------------------------
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, osc = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, oa, ob;
	logic [2:0] irq_ack = 3'h0, irq_req;
	int miscompares = 0, compares = 0, cyc = 0, i;

	tmr8c_timer tmr8c_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq_ack(irq_ack), .irq_req(irq_req), .osc_pin_in(osc),
		.compare_output_a(oa), .compare_output_b(ob));

	always #2 pclk = ~pclk;

	// Bounds a hang; all scenarios fit well inside this
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc >= 20000)
		begin
			miscompares++;
			end_sim();
		end
	end

	// ---------------------------------------------------------------
	// Bus and compare tasks
	// ---------------------------------------------------------------
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		// Only pready or the bench timeout ends this wait
		while (pready !== 1'b1)
		begin
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		// Idle edge keeps the release apart from the next setup
		@(posedge pclk);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		compares++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic chkb(input logic got, input logic exp, input string m);
		compares++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: %s got %b exp %b", $time, m, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1, a, d);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string m);
		apb(0, a, 8'h00);
		chk(rd, {24'h0, e}, m);
	endtask

	// Poll flags until the given bit sets, bounded
	task automatic wait_flag(input int b);
		int n;
		n = 0;
		apb(0, ADDR_FLAGS, 8'h00);
		while (rd[b] !== 1'b1 && n < 300)
		begin
			n++;
			apb(0, ADDR_FLAGS, 8'h00);
		end
		chkb(rd[b], 1'b1, "flag set");
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_reset_map();
		rdchk(ADDR_COUNT, RST_BYTE, "count reset");
		rdchk(ADDR_FLAGS, 8'h00, "flags reset");
		apb(0, 8'h40, 8'h00);
		chkb(err, 1'b1, "unmapped error");
		wr(ADDR_COUNT, 8'h12);
		repeat (10) @(posedge pclk);
		rdchk(ADDR_COUNT, 8'h12, "stopped count");
		$display("test reset_map done");
	endtask

	task automatic t_overflow();
		wr(ADDR_COUNT, 8'hfd);
		wr(ADDR_MASK, 8'h01);
		wr(ADDR_CTRL_B, 8'h01);
		wait_flag(0);
		@(posedge pclk);
		chkb(irq_req[0], 1'b1, "ovf request");
		chkb(irq_req[2], 1'b0, "masked request");
		wr(ADDR_CTRL_B, 8'h00);
		wr(ADDR_FLAGS, 8'h07);
		rdchk(ADDR_FLAGS, 8'h00, "ovf cleared");
		$display("test overflow done");
	endtask

	task automatic t_match_ack();
		wr(ADDR_CTRL_B, 8'h00);
		wr(ADDR_COUNT, 8'h00);
		wr(ADDR_CMP_A, 8'h08);
		wr(ADDR_MASK, 8'h02);
		wr(ADDR_CTRL_B, 8'h01);
		wait_flag(1);
		wr(ADDR_CTRL_B, 8'h00);
		chkb(irq_req[1], 1'b1, "cmp a request");
		irq_ack <= 3'h2;
		@(posedge pclk);
		irq_ack <= 3'h0;
		rdchk(ADDR_FLAGS, 8'h00, "ack clears flag");
		$display("test match_ack done");
	endtask

	task automatic t_block();
		wr(ADDR_CMP_B, 8'h30);
		wr(ADDR_COUNT, 8'h30);
		wr(ADDR_FLAGS, 8'h07);
		wr(ADDR_CTRL_B, 8'h01);
		repeat (10) @(posedge pclk);
		wr(ADDR_CTRL_B, 8'h00);
		apb(0, ADDR_FLAGS, 8'h00);
		chkb(rd[2], 1'b0, "blocked match");
		$display("test block done");
	endtask

	task automatic t_force();
		logic [1:0] act [4];
		logic e;
		act = '{ACT_TOGGLE, ACT_NONE, ACT_CLEAR, ACT_SET};
		e = oa;
		for (i = 0; i < 4; i++)
		begin
			wr(ADDR_CTRL_A, {act[i], 6'h00});
			wr(ADDR_CTRL_B, 8'h80);
			@(posedge pclk);
			e = (act[i] == ACT_TOGGLE) ? ~e : (act[i] == ACT_SET) ? 1'b1 : (act[i] == ACT_CLEAR) ? 1'b0 : e;
			chkb(oa, e, "forced output");
		end
		wr(ADDR_CTRL_A, 8'h10);
		wr(ADDR_CTRL_B, 8'h40);
		@(posedge pclk);
		chkb(ob, 1'b1, "forced output b");
		wr(ADDR_CTRL_A, 8'h00);
		rdchk(ADDR_CTRL_B, 8'h00, "force reads zero");
		rdchk(ADDR_FLAGS, 8'h00, "force sets no flag");
		$display("test force done");
	endtask

	task automatic t_ctc();
		wr(ADDR_CTRL_A, 8'h02);
		wr(ADDR_CMP_A, 8'h04);
		wr(ADDR_COUNT, 8'h00);
		wr(ADDR_CTRL_B, 8'h01);
		for (i = 0; i < 12; i++)
		begin
			apb(0, ADDR_COUNT, 8'h00);
			chkb(rd[7:0] <= 8'h04, 1'b1, "ctc top");
		end
		wr(ADDR_CTRL_B, 8'h00);
		$display("test ctc done");
	endtask

	task automatic t_pwm_buffer();
		wr(ADDR_CTRL_A, 8'h03);
		wr(ADDR_COUNT, 8'h00);
		wr(ADDR_CMP_B, 8'h05);
		rdchk(ADDR_CMP_B, 8'h05, "buffer readback");
		wr(ADDR_FLAGS, 8'h07);
		wr(ADDR_CTRL_B, 8'h01);
		repeat (16) @(posedge pclk);
		wr(ADDR_CTRL_B, 8'h00);
		apb(0, ADDR_FLAGS, 8'h00);
		chkb(rd[2], 1'b0, "buffered compare idle");
		$display("test pwm_buffer done");
	endtask

	task automatic t_fast_top_a();
		wr(ADDR_CTRL_A, 8'h03);
		wr(ADDR_COUNT, 8'h00);
		wr(ADDR_CTRL_B, 8'h09);
		for (i = 0; i < 8; i++)
		begin
			apb(0, ADDR_COUNT, 8'h00);
			chkb(rd[7:0] <= 8'h04, 1'b1, "fast pwm top a");
		end
		wr(ADDR_CTRL_B, 8'h00);
		$display("test fast_top_a done");
	endtask

	task automatic t_async();
		wr(ADDR_CTRL_A, 8'h00);
		wr(ADDR_ASYNC, 8'h01);
		wr(ADDR_COUNT, 8'h00);
		wr(ADDR_CTRL_B, 8'h01);
		repeat (10) @(posedge pclk);
		rdchk(ADDR_COUNT, 8'h00, "no oscillator edge");
		for (i = 0; i < 5; i++)
		begin
			osc <= 1'b1;
			repeat (4) @(posedge pclk);
			osc <= 1'b0;
			repeat (4) @(posedge pclk);
		end
		rdchk(ADDR_COUNT, 8'h05, "oscillator edges counted");
		wr(ADDR_CTRL_B, 8'h00);
		wr(ADDR_ASYNC, 8'h00);
		$display("test async done");
	endtask

	task automatic end_sim();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (2) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		t_reset_map();
		t_overflow();
		t_match_ack();
		t_block();
		t_force();
		t_ctc();
		t_pwm_buffer();
		t_fast_top_a();
		t_async();
		end_sim();
	end
endmodule // tmr8c_timer_test

`default_nettype wire
